// ---- design/icdr_top.sv ----
// cache-inspect debug read path and debug-data special register
`timescale 1ns/10ps
module icdr_top #(
  parameter int SETS = 256,
  parameter int WORDS = 8
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // cache-inspect request from the pipeline
  input wire logic INSPECT_REQ,
  input wire logic [31:0] INSPECT_EA,
  input wire logic WAY_SELECT_BIT,
  input wire logic LINE_FIELD_A_SELECT_BIT,
  input wire logic PARITY_READ_BIT,
  output logic INSPECT_BUSY,
  output logic INSPECT_DONE,
  // special register read
  input wire logic SPR_RD,
  input wire logic [9:0] SPR_NUM,
  input wire logic SUPERVISOR,
  output logic [31:0] SPR_RDATA,
  output logic SPR_ACK,
  output logic SPR_PRIV_FAULT,
  // cache fill port
  input wire logic FILL_EN,
  input wire logic FILL_WAY,
  input wire logic [$clog2(SETS)-1:0] FILL_SET,
  input wire logic [$clog2(WORDS)-1:0] FILL_WORD,
  input wire logic [31:0] FILL_DATA,
  input wire logic [3:0] FILL_PAR,
  input wire logic [21:0] FILL_TAG,
  input wire logic FILL_TAG_PARITY_BIT,
  input wire logic FILL_VALID,
  input wire logic FILL_LRU
);
  localparam int SW = $clog2(SETS);
  localparam int WW = $clog2(WORDS);
  localparam int TW = icdr_pkg::TAG_W;
  localparam int PW = icdr_pkg::PAR_W;

  //////////////////////////////////////////////////////////////////////////////
  // big-endian bit placement helper
  function automatic int be(input int pos);
    be = 31 - pos;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // request capture
  icdr_pkg::icdr_state_e state_q, state_d;
  logic way_q, line_field_a_q, par_q;
  logic [SW-1:0] set_q;
  logic [WW-1:0] word_q;
  logic [31:0] data_q;
  logic busy_q, done_q, ack_q, fault_q;
  logic [31:0] rdata_q;

  wire take = (state_q == icdr_pkg::ICDR_IDLE) && INSPECT_REQ;
  wire [SW-1:0] ea_set = INSPECT_EA[be(icdr_pkg::EA_CLASS_LO) +: SW];
  wire [WW-1:0] ea_word = INSPECT_EA[be(icdr_pkg::EA_WORD_LO) +: WW];

  //////////////////////////////////////////////////////////////////////////////
  // arrays
  logic [31:0] w_a, w_b;
  logic [PW-1:0] p_a, p_b;
  logic [TW-1:0] t_a, t_b;
  logic [1:0] tp, vl;
  logic lru;

  icdr_arrays #(.SETS(SETS), .WORDS(WORDS), .TAG_W(TW), .PAR_W(PW)) icdr_arrays_i (
    .clk(CORE_CLK),
    .wr_en(FILL_EN),
    .wr_way(FILL_WAY),
    .wr_set(FILL_SET),
    .wr_word(FILL_WORD),
    .wr_data(FILL_DATA),
    .wr_par(FILL_PAR),
    .wr_tag(FILL_TAG),
    .wr_tag_parity_bit(FILL_TAG_PARITY_BIT),
    .wr_valid(FILL_VALID),
    .wr_lru(FILL_LRU),
    .rd_en(state_q == icdr_pkg::ICDR_WAIT),
    .rd_set(set_q),
    .rd_word(word_q),
    .rd_word_a(w_a),
    .rd_word_b(w_b),
    .rd_par_a(p_a),
    .rd_par_b(p_b),
    .rd_tag_a(t_a),
    .rd_tag_b(t_b),
    .rd_tag_parity_bit(tp),
    .rd_valid(vl),
    .rd_lru(lru)
  );

  //////////////////////////////////////////////////////////////////////////////
  // result formatting, reserved bits zero
  wire [31:0] sel_word = way_q ? w_b : w_a;
  wire [TW-1:0] sel_tag = way_q ? t_b : t_a;
  wire sel_valid = way_q ? vl[1] : vl[0];
  wire sel_tag_parity_bit = way_q ? tp[1] : tp[0];
  logic [31:0] fmt;
  always_comb begin
    fmt = 32'h0000_0000;
    if (!line_field_a_q && !par_q) begin
      fmt = sel_word;
    end else if (!line_field_a_q) begin
      fmt[31 -: PW] = p_a;
      fmt[31-PW -: PW] = p_b;
    end else begin
      fmt[31 -: TW] = sel_tag;
      fmt[be(icdr_pkg::POS_VALID)] = sel_valid;
      fmt[be(icdr_pkg::POS_LRU)] = lru;
      if (par_q) begin
        fmt[be(icdr_pkg::POS_TAG_PARITY_BIT)] = sel_tag_parity_bit;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      icdr_pkg::ICDR_IDLE: if (INSPECT_REQ) state_d = icdr_pkg::ICDR_WAIT;
      icdr_pkg::ICDR_WAIT: state_d = icdr_pkg::ICDR_LOAD;
      icdr_pkg::ICDR_LOAD: state_d = icdr_pkg::ICDR_IDLE;
      default: state_d = icdr_pkg::ICDR_IDLE;
    endcase
  end

  wire spr_hit = SPR_RD && (SPR_NUM == icdr_pkg::SPR_DEBUG_DATA);

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state_q <= icdr_pkg::ICDR_IDLE;
      way_q <= 1'b0;
      line_field_a_q <= 1'b0;
      par_q <= 1'b0;
      set_q <= '0;
      word_q <= '0;
      data_q <= icdr_pkg::DEBUG_DATA_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      fault_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d != icdr_pkg::ICDR_IDLE);
      done_q <= (state_q == icdr_pkg::ICDR_LOAD);
      if (take) begin
        way_q <= WAY_SELECT_BIT;
        line_field_a_q <= LINE_FIELD_A_SELECT_BIT;
        par_q <= PARITY_READ_BIT;
        set_q <= ea_set;
        word_q <= ea_word;
      end
      if (state_q == icdr_pkg::ICDR_LOAD) begin
        data_q <= fmt;
      end
      ack_q <= spr_hit;
      fault_q <= spr_hit && !SUPERVISOR;
      if (spr_hit) begin
        rdata_q <= SUPERVISOR ? data_q : 32'h0000_0000;
      end
    end
  end

  assign INSPECT_BUSY = busy_q;
  assign INSPECT_DONE = done_q;
  assign SPR_RDATA = rdata_q;
  assign SPR_ACK = ack_q;
  assign SPR_PRIV_FAULT = fault_q;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_take;
    take;
  endsequence
  sequence s_done;
    ##3 INSPECT_DONE;
  endsequence

  a_done_after_take: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_take |-> s_done)
    else $error("inspect did not finish in three cycles");
  a_busy_window: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_take |=> INSPECT_BUSY ##1 INSPECT_BUSY ##1 !INSPECT_BUSY)
    else $error("busy window wrong");
  a_word_mode: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == icdr_pkg::ICDR_LOAD && !line_field_a_q && !par_q) |=>
    data_q == $past(way_q ? w_b : w_a))
    else $error("word mode data wrong");
  a_way_select: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == icdr_pkg::ICDR_LOAD && line_field_a_q) |=>
    data_q[31 -: TW] == $past(way_q ? t_b : t_a))
    else $error("tag from wrong way");
  a_parity_word: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == icdr_pkg::ICDR_LOAD && !line_field_a_q && par_q) |=>
    data_q == {$past(p_a), $past(p_b), 24'h000000})
    else $error("parity word layout wrong");
  a_tag_reserved: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == icdr_pkg::ICDR_LOAD && line_field_a_q && !par_q) |=>
    data_q[9:5] == 5'h00 && data_q[3:1] == 3'h0 && data_q[0] == $past(lru))
    else $error("tag mode reserved or lru wrong");
  a_tag_parity: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == icdr_pkg::ICDR_LOAD && line_field_a_q && par_q) |=>
    data_q[6] == $past(way_q ? tp[1] : tp[0]) && data_q[4] == $past(way_q ? vl[1] : vl[0]))
    else $error("tag parity or valid wrong");
  a_class_capture: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    take |=> set_q == $past(INSPECT_EA[12:5]) && word_q == $past(INSPECT_EA[4:2]))
    else $error("class or word index wrong");
  a_spr_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (spr_hit && SUPERVISOR) |=> SPR_ACK && SPR_RDATA == $past(data_q))
    else $error("debug register read wrong");
  a_priv_fault: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (spr_hit && !SUPERVISOR) |=> SPR_PRIV_FAULT && SPR_RDATA == 32'h0000_0000)
    else $error("user read not refused");
endmodule

// ---- design/icdr_pkg.sv ----
// constants for the instruction-cache debug read path
package icdr_pkg;
  // bit numbers below are big-endian (bit 0 is the msb)
  localparam int EA_CLASS_HI = 19;
  localparam int EA_CLASS_LO = 26;
  localparam int EA_WORD_HI = 27;
  localparam int EA_WORD_LO = 29;
  localparam int TAG_W = 22;
  localparam int POS_VALID = 27;
  localparam int POS_LRU = 31;
  localparam int POS_TAG_PARITY_BIT = 25;
  localparam int PAR_W = 4;
  localparam logic [9:0] SPR_DEBUG_DATA = 10'h3d3;
  localparam logic [31:0] DEBUG_DATA_RESET = 32'h0000_0000;
  localparam int LOOKUP_LATENCY = 2;
  typedef enum logic [1:0] {ICDR_IDLE, ICDR_WAIT, ICDR_LOAD} icdr_state_e;
endpackage

// ---- design/icdr_arrays.sv ----
// two-way instruction cache arrays with a registered debug read port
`timescale 1ns/10ps
module icdr_arrays #(
  parameter int SETS = 256,
  parameter int WORDS = 8,
  parameter int TAG_W = 22,
  parameter int PAR_W = 4
) (
  // clock
  input wire logic clk,
  // fill port
  input wire logic wr_en,
  input wire logic wr_way,
  input wire logic [$clog2(SETS)-1:0] wr_set,
  input wire logic [$clog2(WORDS)-1:0] wr_word,
  input wire logic [31:0] wr_data,
  input wire logic [PAR_W-1:0] wr_par,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic wr_tag_parity_bit,
  input wire logic wr_valid,
  input wire logic wr_lru,
  // read port
  input wire logic rd_en,
  input wire logic [$clog2(SETS)-1:0] rd_set,
  input wire logic [$clog2(WORDS)-1:0] rd_word,
  output logic [31:0] rd_word_a,
  output logic [31:0] rd_word_b,
  output logic [PAR_W-1:0] rd_par_a,
  output logic [PAR_W-1:0] rd_par_b,
  output logic [TAG_W-1:0] rd_tag_a,
  output logic [TAG_W-1:0] rd_tag_b,
  output logic [1:0] rd_tag_parity_bit,
  output logic [1:0] rd_valid,
  output logic rd_lru
);
  logic [31:0] word_mem [2][SETS*WORDS];
  logic [PAR_W-1:0] par_mem [2][SETS*WORDS];
  logic [TAG_W-1:0] tag_mem [2][SETS];
  logic tag_parity_bit_mem [2][SETS];
  logic valid_mem [2][SETS];
  logic lru_mem [SETS];
  wire [$clog2(SETS*WORDS)-1:0] wr_idx = {wr_set, wr_word};
  wire [$clog2(SETS*WORDS)-1:0] rd_idx = {rd_set, rd_word};

  always_ff @(posedge clk) begin
    if (wr_en) begin
      word_mem[wr_way][wr_idx] <= wr_data;
      par_mem[wr_way][wr_idx] <= wr_par;
      tag_mem[wr_way][wr_set] <= wr_tag;
      tag_parity_bit_mem[wr_way][wr_set] <= wr_tag_parity_bit;
      valid_mem[wr_way][wr_set] <= wr_valid;
      lru_mem[wr_set] <= wr_lru;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_word_a <= word_mem[0][rd_idx];
      rd_word_b <= word_mem[1][rd_idx];
      rd_par_a <= par_mem[0][rd_idx];
      rd_par_b <= par_mem[1][rd_idx];
      rd_tag_a <= tag_mem[0][rd_set];
      rd_tag_b <= tag_mem[1][rd_set];
      rd_tag_parity_bit <= {tag_parity_bit_mem[1][rd_set], tag_parity_bit_mem[0][rd_set]};
      rd_valid <= {valid_mem[1][rd_set], valid_mem[0][rd_set]};
      rd_lru <= lru_mem[rd_set];
    end
  end
endmodule

// ---- tb/icdr_core_model.sv ----
// core-side model issuing cache-inspect requests and register reads
`timescale 1ns/10ps
module icdr_core_model (
  // clock
  input wire logic clk,
  // inspect request
  output logic req,
  output logic [31:0] ea,
  output logic way,
  output logic line_field_a,
  output logic par,
  input wire logic done,
  // register read
  output logic rd,
  output logic [9:0] num,
  output logic sup,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic fault
);
  initial begin
    {req, way, line_field_a, par, rd, sup} = 6'h00;
    ea = 32'h0000_0000;
    num = 10'h000;
  end
  // request held one edge, then address shows its inverse
  task automatic inspect(input logic [31:0] a, input logic [2:0] wip, output int n);
    @(posedge clk);
    #1;
    req = 1'b1;
    ea = a;
    {way, line_field_a, par} = wip;
    @(posedge clk);
    #1;
    req = 1'b0;
    ea = ~a;
    // n counts edges from the take to the edge that samples done high
    n = 1;
    // read only after completion, as a synchronising step does
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
  endtask
  task automatic spr_read(input logic [9:0] nm, input logic s, output logic [31:0] d,
                          output logic a, output logic f);
    @(posedge clk);
    #1;
    rd = 1'b1;
    num = nm;
    sup = s;
    @(posedge clk);
    #1;
    rd = 1'b0;
    num = ~nm;
    d = rdata;
    a = ack;
    f = fault;
  endtask
endmodule

// ---- tb/icache_debug_read_bench.sv ----
// self-checking bench for the cache-inspect debug read path
`timescale 1ns/10ps
module icache_debug_read_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req, way, line_field_a, par, rd, sup, busy, done, ack, fault;
  logic [31:0] ea, rdata;
  logic [9:0] num;
  logic fill_en = 1'b0;
  logic fill_way = 1'b0;
  logic [7:0] fill_set = 8'h00;
  logic [2:0] fill_word = 3'h0;
  logic [31:0] fill_data = 32'h0000_0000;
  logic [3:0] fill_par = 4'h0;
  logic [21:0] fill_tag = 22'h000000;
  logic [2:0] fill_st = 3'h0;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  icdr_core_model icdr_core_model_i (.clk(clk), .req(req), .ea(ea), .way(way),
    .line_field_a(line_field_a), .par(par), .done(done), .rd(rd), .num(num), .sup(sup),
    .rdata(rdata), .ack(ack), .fault(fault));
  icdr_top #(.SETS(256), .WORDS(8)) icdr_top_i (.CORE_CLK(clk), .NRST(nrst),
    .INSPECT_REQ(req), .INSPECT_EA(ea), .WAY_SELECT_BIT(way),
    .LINE_FIELD_A_SELECT_BIT(line_field_a), .PARITY_READ_BIT(par), .INSPECT_BUSY(busy),
    .INSPECT_DONE(done), .SPR_RD(rd), .SPR_NUM(num), .SUPERVISOR(sup),
    .SPR_RDATA(rdata), .SPR_ACK(ack), .SPR_PRIV_FAULT(fault), .FILL_EN(fill_en),
    .FILL_WAY(fill_way), .FILL_SET(fill_set), .FILL_WORD(fill_word),
    .FILL_DATA(fill_data), .FILL_PAR(fill_par), .FILL_TAG(fill_tag),
    .FILL_TAG_PARITY_BIT(fill_st[2]), .FILL_VALID(fill_st[1]), .FILL_LRU(fill_st[0]));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [21:0] tg(logic w, logic [7:0] s);
    return {s, 13'h0a5b, w};
  endfunction
  function automatic logic [31:0] dt(logic w, logic [7:0] s, logic [2:0] k);
    return {w ? 8'hb0 : 8'ha0, s, 8'h3c, 5'h00, k};
  endfunction
  function automatic logic [3:0] pa(logic w, logic [7:0] s);
    return w ? (4'h1 ^ s[3:0]) : (4'h9 ^ s[7:4]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // way a valid, way b invalid; class lru follows set bit 0
  task automatic fill(input logic w, input logic [7:0] s);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      {fill_en, fill_way, fill_set, fill_word} = {1'b1, w, s, 3'(k)};
      fill_data = dt(w, s, 3'(k));
      fill_par = pa(w, s);
      fill_tag = tg(w, s);
      fill_st = {w ^ s[0], ~w, s[0]};
    end
    @(posedge clk);
    #1;
    fill_en = 1'b0;
  endtask
  // reset value, privilege, unmapped number
  task automatic t_sprreg();
    logic [31:0] d;
    logic a, f;
    icdr_core_model_i.spr_read(10'h3d3, 1'b1, d, a, f);
    chk("ack", {31'h0, a}, 32'h1);
    chk("reset data", d, 32'h0000_0000);
    icdr_core_model_i.spr_read(10'h3d2, 1'b1, d, a, f);
    chk("unmapped ack", {31'h0, a}, 32'h0);
    icdr_core_model_i.spr_read(10'h3d3, 1'b0, d, a, f);
    chk("fault", {31'h0, f}, 32'h1);
    chk("fault data", d, 32'h0000_0000);
  endtask
  // every mode and way on one class, word 7 for odd classes, else 0
  task automatic t_modes(input logic [7:0] s);
    logic [31:0] d, e;
    logic a, f;
    logic [2:0] k;
    int n;
    k = s[0] ? 3'h7 : 3'h0;
    for (int m = 0; m < 8; m++) begin
      // m[0] picks the way, m[1] line_field_a-select, m[2] parity-read
      fork
        icdr_core_model_i.inspect({19'h0, s, k, 2'h0}, {m[0], m[1], m[2]}, n);
        begin
          repeat (2) @(posedge clk);
          #2;
          chk("busy", {31'h0, busy}, 32'h1);
        end
      join
      chk("latency", 32'(n), 32'd3);
      chk("idle", {31'h0, busy}, 32'h0);
      case (m[2:1])
        2'h0: e = dt(m[0], s, k);
        2'h1: e = {tg(m[0], s), 5'h00, ~m[0], 3'h0, s[0]};
        2'h2: e = {pa(1'b0, s), pa(1'b1, s), 24'h000000};
        default: e = {tg(m[0], s), 3'h0, m[0] ^ s[0], 1'b0, ~m[0], 3'h0, s[0]};
      endcase
      icdr_core_model_i.spr_read(10'h3d3, 1'b1, d, a, f);
      chk("read ack", {31'h0, a}, 32'h1);
      chk("debug data", d, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_sprreg();
    fill(1'b0, 8'ha5);
    fill(1'b1, 8'ha5);
    fill(1'b0, 8'h5a);
    fill(1'b1, 8'h5a);
    t_modes(8'ha5);
    t_modes(8'h5a);
    complete_run();
  end
endmodule
